// file: rtl/sefc_device.sv
// Device end: erase-prepare, erase-unit and freeze-lock command handling.
// Assumes the host raises cmd_valid for one cycle only while not busy.
//
// Summary of operation
// - Code F4h starts erase unit
// - Wipe sectors first, then drop lock
// - Erase LBA 0 to native maximum
// - Erase unit takes one parameter sector
// - Lock off plus user id aborts
// - Wrong password aborts erase unit
// - Word 0 id and mode, 1-16 password
// - Only normal erase mode supported
// - Id selects user or master password
// - Write zeros, no read-back check
// - Defect lists stay unchanged
// - Host sends prepare right before erase
// - Erase without prepare is aborted
// - Master password kept after erase
// - Lock off skips password compare
// - Erase time reported in identify word 89
// - Code F5h is freeze, no data
// - Freeze takes effect at once
// - Frozen rejects lock-changing commands
// - Only power-off clears frozen
// - Code F3h arms erase, no data
`timescale 1ns/1ns
module sefc_device #(
    parameter logic [31:0] NATIVE_MAX_LBA = 32'h0000_00FF,
    parameter logic [15:0] ERASE_TIME = 16'h0001,
    parameter logic [255:0] USER_PW_INIT = 256'h0,
    parameter logic [255:0] MASTER_PW_INIT = 256'h0,
    parameter logic LOCK_INIT = 1'b1
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Power-on clear of the frozen state
    input wire logic POWER_ON_RST,
    // Host link
    sefc_if.dev LINK,
    // Media write port
    output logic MEDIA_WE,
    output logic [31:0] MEDIA_LBA,
    output logic MEDIA_ZERO,
    // Security state
    output logic LOCK_ENABLED,
    output logic FROZEN
);
    typedef enum {ST_IDLE, ST_DATA, ST_CHECK, ST_WIPE, ST_FINISH} sefc_state_e;
    sefc_state_e state;
    logic armed;
    logic id_master;
    logic mode_enh;
    logic [8:0] word_cnt;
    logic [255:0] pw_rx;
    logic [255:0] user_pw;
    logic [255:0] master_pw;
    logic abort_now;
    logic pw_ok;
    logic erase_cmd;

    assign erase_cmd = LINK.cmd_valid && LINK.cmd_code == sefc_pkg::CMD_ERASE_UNIT;
    assign pw_ok = id_master ? (pw_rx == master_pw) : (pw_rx == user_pw);
    // Passwords stay held through erase; master is never cleared
    assign user_pw = USER_PW_INIT;
    assign master_pw = MASTER_PW_INIT;

    // ==========================================================
    // Immediate abort decision at command accept
    always_comb begin
        abort_now = 1'b0;
        if (LINK.cmd_valid) begin
            case (LINK.cmd_code)
                sefc_pkg::CMD_SET_PW, sefc_pkg::CMD_UNLOCK, sefc_pkg::CMD_DISABLE_PW:
                    abort_now = FROZEN;
                sefc_pkg::CMD_ERASE_UNIT:
                    abort_now = FROZEN || !armed;
                default:
                    abort_now = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Prepare arming
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            armed <= 1'b0;
        end else if (LINK.cmd_valid) begin
            armed <= LINK.cmd_code == sefc_pkg::CMD_ERASE_PREP;
        end
    end

    // ==========================================================
    // Frozen: survives RST, cleared only at power-on
    always_ff @(posedge CORE_CLK) begin
        if (POWER_ON_RST) begin
            FROZEN <= 1'b0;
        end else if (LINK.cmd_valid && LINK.cmd_code == sefc_pkg::CMD_FREEZE) begin
            FROZEN <= 1'b1;
        end
    end

    // ==========================================================
    // Command sequencer
    always_ff @(posedge CORE_CLK) begin
        if (POWER_ON_RST) begin
            LOCK_ENABLED <= LOCK_INIT;
        end else if (state == ST_WIPE && MEDIA_LBA == NATIVE_MAX_LBA && MEDIA_WE) begin
            LOCK_ENABLED <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            word_cnt <= 9'h000;
            pw_rx <= 256'h0;
            id_master <= 1'b0;
            mode_enh <= 1'b0;
            MEDIA_WE <= 1'b0;
            MEDIA_LBA <= 32'h0;
            MEDIA_ZERO <= 1'b0;
            LINK.wready <= 1'b0;
            LINK.done <= 1'b0;
            LINK.command_error_report <= 8'h00;
            LINK.drive_condition_report <= 8'h50;
        end else begin
            LINK.done <= 1'b0;
            MEDIA_WE <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (LINK.cmd_valid) begin
                        LINK.command_error_report <= 8'h00;
                        if (abort_now) begin
                            LINK.command_error_report[sefc_pkg::ERR_ABORTED] <= 1'b1;
                            LINK.drive_condition_report <= 8'h51;
                            LINK.done <= 1'b1;
                        end else if (erase_cmd) begin
                            word_cnt <= 9'h000;
                            LINK.wready <= 1'b1;
                            LINK.drive_condition_report <= 8'h58;
                            state <= ST_DATA;
                        end else begin
                            LINK.drive_condition_report <= 8'h50;
                            LINK.done <= 1'b1;
                        end
                    end
                end
                ST_DATA: begin
                    if (LINK.wvalid) begin
                        if (word_cnt == 9'(sefc_pkg::CTRL_WORD)) begin
                            id_master <= LINK.wdata[sefc_pkg::ID_BIT];
                            mode_enh <= LINK.wdata[sefc_pkg::MODE_BIT];
                        end else if (word_cnt <= 9'(sefc_pkg::PW_LAST_WORD)) begin
                            pw_rx <= {LINK.wdata, pw_rx[255:16]};
                        end
                        word_cnt <= word_cnt + 9'h001;
                        if (word_cnt == 9'(sefc_pkg::SECTOR_WORDS - 1)) begin
                            LINK.wready <= 1'b0;
                            state <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    // Enhanced mode is unsupported and aborts
                    if (mode_enh
                        || (!LOCK_ENABLED && !id_master)
                        || (LOCK_ENABLED && !pw_ok)) begin
                        LINK.command_error_report[sefc_pkg::ERR_ABORTED] <= 1'b1;
                        LINK.drive_condition_report <= 8'h51;
                        LINK.done <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        MEDIA_LBA <= 32'(sefc_pkg::ERASE_FIRST_LBA);
                        MEDIA_ZERO <= 1'b1;
                        MEDIA_WE <= 1'b1;
                        LINK.drive_condition_report <= 8'h80;
                        state <= ST_WIPE;
                    end
                end
                ST_WIPE: begin
                    // Write only, no verify; defect lists untouched
                    if (MEDIA_LBA == NATIVE_MAX_LBA) begin
                        MEDIA_ZERO <= 1'b0;
                        state <= ST_FINISH;
                    end else begin
                        MEDIA_LBA <= MEDIA_LBA + 32'h1;
                        MEDIA_WE <= 1'b1;
                    end
                end
                ST_FINISH: begin
                    LINK.drive_condition_report <= 8'h50;
                    LINK.done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Identify word 89 content
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            // Same value in reset: identify content must not drop out around reset
            LINK.erase_time <= ERASE_TIME;
        end else begin
            LINK.erase_time <= ERASE_TIME;
        end
    end
endmodule : sefc_device

// file: rtl/sefc_pkg.sv
// Shared constants for the security erase / freeze-lock command path.
// Assumes one clock domain shared by host controller and device end.
package sefc_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
    localparam logic [7:0] CMD_FREEZE = 8'hF5;
    localparam logic [7:0] CMD_SET_PW = 8'hF1;
    localparam logic [7:0] CMD_UNLOCK = 8'hF2;
    localparam logic [7:0] CMD_DISABLE_PW = 8'hF6;
    // ==========================================================
    // Parameter block layout (16-bit words)
    localparam int CTRL_WORD = 0;
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD = 16;
    localparam int SECTOR_WORDS = 256;
    localparam int ID_BIT = 0;
    localparam int MODE_BIT = 1;
    localparam int ERASE_FIRST_LBA = 0;
    localparam int IDENT_TIME_WORD = 89;
    // ==========================================================
    // Error and status bit positions
    localparam int ERR_SECTOR_MISSING = 4;
    localparam int ERR_ABORTED = 2;
    localparam int ST_OCCUPIED = 7;
    localparam int ST_READY = 6;
    localparam int ST_FAULT = 5;
    localparam int ST_SEEK_SETTLED = 4;
    localparam int ST_XFER_REQ = 3;
    localparam int ST_ERROR = 0;
    // ==========================================================
    // Host APB register map (byte offsets)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_PW_BASE = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h28;
    localparam logic [7:0] REG_IDENT = 8'h2C;
    localparam int PW_REGS = 8;
endpackage : sefc_pkg

// file: rtl/sefc_if.sv
// Taskfile-style link between host controller and device end.
// Assumes both ends share CORE_CLK; data words move on valid/ready.
`timescale 1ns/1ns
interface sefc_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [15:0] wdata;
    logic wvalid;
    logic wready;
    logic [7:0] command_error_report;
    logic [7:0] drive_condition_report;
    logic done;
    logic [15:0] erase_time;
    modport dev (input cmd_valid, cmd_code, wdata, wvalid,
        output wready, command_error_report, drive_condition_report, done, erase_time);
    modport host (output cmd_valid, cmd_code, wdata, wvalid,
        input wready, command_error_report, drive_condition_report, done, erase_time);
endinterface : sefc_if

// file: rtl/sefc_host.sv
// Host end: APB registers drive commands and the parameter sector.
// Assumes the device end answers every command with a done pulse.
`timescale 1ns/1ns
module sefc_host (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Device link
    sefc_if.host LINK
);
    logic [7:0] cmd_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] pw_reg [sefc_pkg::PW_REGS];
    logic busy;
    logic [8:0] word_idx;
    logic [7:0] err_seen;
    logic [7:0] st_seen;
    logic acc;
    logic [15:0] next_word;
    logic addr_bad;

    assign acc = PSEL && PENABLE;
    // Only aligned words 00..2C are mapped
    assign addr_bad = PADDR > sefc_pkg::REG_IDENT || PADDR[1:0] != 2'b00;

    // Word 0 control, 1-16 password, remainder zero
    always_comb begin
        next_word = 16'h0000;
        if (word_idx == 9'(sefc_pkg::CTRL_WORD)) begin
            next_word = {14'h0, ctrl_reg};
        end else if (word_idx <= 9'(sefc_pkg::PW_LAST_WORD)) begin
            next_word = word_idx[0] ? pw_reg[3'((word_idx - 9'h1) >> 1)][15:0]
                : pw_reg[3'((word_idx - 9'h1) >> 1)][31:16];
        end
    end

    // ==========================================================
    // APB register file and command issue
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cmd_reg <= 8'h00;
            ctrl_reg <= 2'b00;
            for (int i = 0; i < sefc_pkg::PW_REGS; i++) begin
                pw_reg[i] <= 32'h0;
            end
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
            LINK.cmd_valid <= 1'b0;
            LINK.cmd_code <= 8'h00;
        end else begin
            LINK.cmd_valid <= 1'b0;
            // One wait state, so read data and error are registered before the completing edge
            PREADY <= acc && !PREADY;
            PSLVERR <= acc && !PREADY && addr_bad;
            if (acc && !PREADY) begin
                PRDATA <= 32'h0;
                if (PADDR == sefc_pkg::REG_RESULT) begin
                    PRDATA <= {15'h0, busy, err_seen, st_seen};
                end else if (PADDR == sefc_pkg::REG_IDENT) begin
                    PRDATA <= {16'h0, LINK.erase_time};
                end else if (PADDR == sefc_pkg::REG_CTRL) begin
                    PRDATA <= {30'h0, ctrl_reg};
                end else if (PADDR == sefc_pkg::REG_CMD) begin
                    PRDATA <= {24'h0, cmd_reg};
                end
            end
            // A write lands only on the edge that completes the transfer
            if (acc && PREADY && PWRITE && !addr_bad) begin
                if (PADDR == sefc_pkg::REG_CMD && !busy) begin
                        // Sequencing prepare then erase is software's duty
                    cmd_reg <= PWDATA[7:0];
                    LINK.cmd_valid <= 1'b1;
                    LINK.cmd_code <= PWDATA[7:0];
                end else if (PADDR == sefc_pkg::REG_CTRL) begin
                    ctrl_reg <= PWDATA[1:0];
                end else if (PADDR >= sefc_pkg::REG_PW_BASE && PADDR < sefc_pkg::REG_RESULT) begin
                    pw_reg[3'((PADDR - sefc_pkg::REG_PW_BASE) >> 2)] <= PWDATA;
                end
            end
        end
    end

    // ==========================================================
    // Parameter sector feed and completion capture
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            busy <= 1'b0;
            word_idx <= 9'h000;
            err_seen <= 8'h00;
            st_seen <= 8'h00;
            LINK.wvalid <= 1'b0;
            LINK.wdata <= 16'h0000;
        end else begin
            if (LINK.cmd_valid) begin
                busy <= 1'b1;
                word_idx <= 9'h000;
            end
            LINK.wvalid <= 1'b0;
            if (busy && LINK.wready && !LINK.wvalid) begin
                LINK.wvalid <= 1'b1;
                LINK.wdata <= next_word;
                word_idx <= word_idx + 9'h001;
            end
            if (LINK.done) begin
                busy <= 1'b0;
                err_seen <= LINK.command_error_report;
                st_seen <= LINK.drive_condition_report;
            end
        end
    end
endmodule : sefc_host

// file: tb/sefc_properties.sv
// Concurrent checks on the link between host end and device end.
// Assumes one CORE_CLK domain and synchronous active-high RST.
`timescale 1ns/1ns
module sefc_properties #(
    parameter logic [15:0] ERASE_TIME = 16'h0001
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] wdata,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [7:0] command_error_report,
    input wire logic [7:0] drive_condition_report,
    input wire logic done,
    input wire logic [15:0] erase_time
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // Helper state: words moved in this command, previous command
    logic [8:0] words;
    logic [7:0] last_code;
    always_ff @(posedge CORE_CLK) begin
        if (RST || cmd_valid) begin
            words <= 9'h000;
        end else if (wvalid && wready) begin
            words <= words + 9'h001;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            last_code <= 8'h00;
        end else if (cmd_valid) begin
            last_code <= cmd_code;
        end
    end
    // ==========================================================
    // Properties
    a_done_single: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    a_done_idle: assert property (done |-> !drive_condition_report[7] && !wready)
        else $error("busy or transfer still up at command end");
    a_abort_err: assert property (done && command_error_report[2] |-> drive_condition_report[0])
        else $error("aborted without error summary");
    a_nodata_quick: assert property (cmd_valid && (cmd_code == sefc_pkg::CMD_ERASE_PREP ||
        cmd_code == sefc_pkg::CMD_FREEZE) |=> done && !wready && !command_error_report[2])
        else $error("no-data command not finished at once");
    a_unarmed_erase: assert property (cmd_valid && cmd_code == sefc_pkg::CMD_ERASE_UNIT &&
        last_code != sefc_pkg::CMD_ERASE_PREP |=> done && command_error_report[2])
        else $error("erase without prepare not aborted");
    a_sector_start: assert property (cmd_valid && cmd_code == sefc_pkg::CMD_ERASE_UNIT &&
        last_code == sefc_pkg::CMD_ERASE_PREP |=> wready || done)
        else $error("armed erase neither asks for data nor ends");
    a_sector_len: assert property ($fell(wready) |-> words == 9'h100)
        else $error("parameter sector not 256 words");
    a_word_bound: assert property (words <= 9'h100)
        else $error("more than one sector taken");
    a_xfer_flag: assert property (wready |-> drive_condition_report[3] && !done)
        else $error("transfer request bit low while asking for data");
    a_ident_time: assert property (erase_time == ERASE_TIME)
        else $error("identify erase time word wrong");
endmodule : sefc_properties

// file: tb/security_erase_freeze_cmds_test.sv
// Bench: APB drives the host end, which drives the device end over the link.
// Assumes the register map and RESULT layout {busy,err,status} of the package.
`timescale 1ns/1ns
module security_erase_freeze_cmds_test;
    localparam logic [31:0] MAXL = 32'h0000_000F;
    localparam logic [15:0] ETIME = 16'h0A5C;
    localparam logic [255:0] UPW = {8{32'h1234ABCD}};
    localparam logic [255:0] MPW = {8{32'h9E37C1F5}};
    localparam logic [31:0] ABORTED_COMMAND_FLAG = 32'h0000_0451;
    localparam logic [31:0] OK = 32'h0000_0050;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic rd_err;
    logic media_we, media_zero, lock, frozen, lock_at_wipe;
    logic [31:0] media_lba;
    int errors = 0, compares = 0, nwr = 0, ndone = 0;
    logic [7:0] codes[4] = '{sefc_pkg::CMD_SET_PW, sefc_pkg::CMD_UNLOCK, sefc_pkg::CMD_DISABLE_PW,
        sefc_pkg::CMD_ERASE_UNIT};
    // ==========================================================
    // Structure
    sefc_if lnk();
    sefc_host i_sefc_host (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(lnk));
    sefc_device #(.NATIVE_MAX_LBA(MAXL), .ERASE_TIME(ETIME), .USER_PW_INIT(UPW), .MASTER_PW_INIT(MPW),
        .LOCK_INIT(1'b1)) i_sefc_device (.CORE_CLK(clk), .RST(rst), .POWER_ON_RST(por), .LINK(lnk),
        .MEDIA_WE(media_we), .MEDIA_LBA(media_lba), .MEDIA_ZERO(media_zero), .LOCK_ENABLED(lock),
        .FROZEN(frozen));
    sefc_properties #(.ERASE_TIME(ETIME)) i_sefc_properties (.CORE_CLK(clk), .RST(rst),
        .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code), .wdata(lnk.wdata), .wvalid(lnk.wvalid),
        .wready(lnk.wready), .command_error_report(lnk.command_error_report),
        .drive_condition_report(lnk.drive_condition_report), .done(lnk.done), .erase_time(lnk.erase_time));
    initial begin
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Monitors sample mid-cycle, away from the register updates
    always @(negedge clk) begin
        if (lnk.done === 1'b1) ndone++;
        if (!rst && media_we === 1'b1) begin
            check("wipe lba", media_lba, nwr % (MAXL + 1));
            check("wipe zero", {31'h0, media_zero}, 32'h1);
            lock_at_wipe = lock;
            nwr++;
        end
    end
    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Request held until pready is seen high at a rising edge; data taken there
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits for the device's done pulse, then fetches RESULT
    task automatic cmd(input logic [7:0] c);
        int n, d0;
        d0 = ndone;
        apb(1'b1, sefc_pkg::REG_CMD, {24'h0, c});
        n = 0;
        while (ndone == d0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (ndone == d0) errors++;
        apb(1'b0, sefc_pkg::REG_RESULT, 32'h0);
    endtask : cmd
    // Loads control word and password, then issues prepare (optional) and the command
    task automatic run(input string nm, input logic [31:0] ctl, input logic [255:0] pw, input logic prep,
        input logic [7:0] c, input logic [31:0] exp);
        apb(1'b1, sefc_pkg::REG_CTRL, ctl);
        for (int k = 0; k < sefc_pkg::PW_REGS; k++) begin
            apb(1'b1, sefc_pkg::REG_PW_BASE + 8'(4 * k), pw[32 * k +: 32]);
        end
        if (prep) cmd(sefc_pkg::CMD_ERASE_PREP);
        cmd(c);
        check(nm, rd, exp);
        $display("test %s finished", nm);
    endtask : run
    task automatic results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0; por <= 1'b0;
        apb(1'b0, sefc_pkg::REG_RESULT, 32'h0);
        check("reset result", rd, 32'h0);
        apb(1'b0, sefc_pkg::REG_IDENT, 32'h0);
        check("ident time", rd, {16'h0, ETIME});
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped slverr", {31'h0, rd_err}, 32'h1);
        $display("test registers finished");
        run("no prepare", 32'h0, UPW, 1'b0, sefc_pkg::CMD_ERASE_UNIT, ABORTED_COMMAND_FLAG);
        run("wrong password", 32'h0, MPW, 1'b1, sefc_pkg::CMD_ERASE_UNIT, ABORTED_COMMAND_FLAG);
        run("enhanced mode", 32'h2, UPW, 1'b1, sefc_pkg::CMD_ERASE_UNIT, ABORTED_COMMAND_FLAG);
        check("no wipe yet", nwr, 0);
        check("still locked", {31'h0, lock}, 32'h1);
        run("master erase", 32'h1, MPW, 1'b1, sefc_pkg::CMD_ERASE_UNIT, OK);
        check("wipe count", nwr, MAXL + 1);
        check("locked while wiping", {31'h0, lock_at_wipe}, 32'h1);
        check("unlocked after", {31'h0, lock}, 32'h0);
        run("user id unlocked", 32'h0, UPW, 1'b1, sefc_pkg::CMD_ERASE_UNIT, ABORTED_COMMAND_FLAG);
        run("no compare", 32'h1, 256'h0, 1'b1, sefc_pkg::CMD_ERASE_UNIT, OK);
        check("second wipe count", nwr, 2 * (MAXL + 1));
        run("freeze", 32'h0, 256'h0, 1'b0, sefc_pkg::CMD_FREEZE, OK);
        check("frozen at once", {31'h0, frozen}, 32'h1);
        foreach (codes[i]) begin
            run("frozen reject", 32'h0, UPW, codes[i] == sefc_pkg::CMD_ERASE_UNIT, codes[i], ABORTED_COMMAND_FLAG);
        end
        check("no wipe while frozen", nwr, 2 * (MAXL + 1));
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("frozen kept by reset", {31'h0, frozen}, 32'h1);
        rst <= 1'b1; por <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0; por <= 1'b0;
        repeat (2) @(posedge clk);
        check("power cycle thaws", {31'h0, frozen}, 32'h0);
        check("lock reloaded", {31'h0, lock}, 32'h1);
        $display("test power cycle finished");
        results();
    end
endmodule : security_erase_freeze_cmds_test
